/* File: hdl/pco_cfg.svh */
// Purpose: offsets, field positions, reset values and timing for the compare block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes: constants only
`ifndef PCO_CFG_SVH
`define PCO_CFG_SVH
// -------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------
`define PCO_OFS_CTRL 12'h000
`define PCO_OFS_RESOL 12'h004
`define PCO_OFS_WIDTH 12'h008
`define PCO_OFS_START 12'h00C
`define PCO_OFS_END 12'h010
`define PCO_OFS_STATUS 12'h014
`define PCO_OFS_LIVE 12'h018
`define PCO_OFS_ZERO 12'h01C
`define PCO_OFS_CYCLES 12'h020
`define PCO_OFS_CASTART 12'h024
`define PCO_OFS_TABLE 12'h100
`define PCO_OFS_TABLE_END 12'h23C
// -------------------------------------------------------------------
// fields and reset values
// -------------------------------------------------------------------
`define PCO_CTRL_EN_BIT 0
`define PCO_CTRL_MODE_LSB 4
`define PCO_CTRL_OPEN_LSB 8
`define PCO_ATTR_UP_BIT 0
`define PCO_ATTR_DN_BIT 1
`define PCO_ATTR_CH_LSB 8
`define PCO_RES_RST 5'h07
`define PCO_RES_BASE 10
`define PCO_WIDTH_MIN 11'h005
`define PCO_WIDTH_RST 11'h005
// -------------------------------------------------------------------
// timing
// -------------------------------------------------------------------
`define PCO_CLK_NS 20
`define PCO_TICK_NS 100000
`define PCO_TICK_CYC (`PCO_TICK_NS / `PCO_CLK_NS)
`endif

/* File: hdl/pco_pkg.sv */
// Purpose: types shared by the compare block
// Assumes: nothing
// Notes: numbers live in pco_cfg.svh
package pco_pkg;
   typedef enum logic [1:0] {
      PCO_SINGLE_ABS = 2'h0,
      PCO_CYC_INC = 2'h1,
      PCO_FIX_INC = 2'h2,
      PCO_CYC_ABS = 2'h3
   } pco_mode_t;
   typedef enum logic [1:0] {
      PCO_ST_IDLE = 2'h0,
      PCO_ST_SEEK = 2'h1,
      PCO_ST_RUN = 2'h2
   } pco_state_t;
endpackage : pco_pkg

/* File: hdl/pco_cross_det.sv */
// Purpose: crossing test of one target between two position samples
// Assumes: samples never wrap across the signed range
// Notes: combinational
`timescale 1ns/1ps
module pco_cross_det
   import pco_pkg::*;
(
   input wire logic signed [31:0] prevPos,
   input wire logic signed [31:0] curPos,
   input wire logic signed [31:0] target,
   input wire logic [1:0] attrDir,
   input wire logic [1:0] dirMask,
   output logic crossUp,
   output logic crossDn,
   output logic fire
);
   // landing on the target counts; the next step leaves it, so a stop there fires once
   assign crossUp = dirMask[0] && (prevPos < target) && (curPos >= target);
   assign crossDn = dirMask[1] && (prevPos > target) && (curPos <= target);
   assign fire = (crossUp && attrDir[0]) || (crossDn && attrDir[1]);
endmodule : pco_cross_det

/* File: hdl/pco_pulse_gen.sv */
// Purpose: fixed-width output pulse on the selected channels
// Assumes: width already clamped to the legal minimum
// Notes: busy marks the suspension window
`timescale 1ns/1ps
`include "pco_cfg.svh"
module pco_pulse_gen
   import pco_pkg::*;
#(
   parameter int TICK_CYC = `PCO_TICK_CYC
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic start,
   input wire logic [10:0] widthTicks,
   input wire logic [3:0] chanSel,
   output logic busy,
   output logic [3:0] chanOut
);
   logic [31:0] cycCnt_r;
   logic [10:0] tickCnt_r;
   logic busy_r;
   logic [3:0] chan_r;
   wire tickEnd = (cycCnt_r == 32'(TICK_CYC - 1));
   wire lastTick = tickEnd && (tickCnt_r == 11'h001);
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cycCnt_r <= 32'h0;
         tickCnt_r <= 11'h0;
         busy_r <= 1'b0;
         chan_r <= 4'h0;
      end
      else if (start && !busy_r)
      begin
         cycCnt_r <= 32'h0;
         tickCnt_r <= widthTicks;
         busy_r <= 1'b1;
         chan_r <= chanSel;
      end
      else if (busy_r)
      begin
         cycCnt_r <= tickEnd ? 32'h0 : cycCnt_r + 32'h1;
         tickCnt_r <= tickEnd ? tickCnt_r - 11'h1 : tickCnt_r;
         busy_r <= !lastTick;
         chan_r <= lastTick ? 4'h0 : chan_r;
      end
   end
   assign busy = busy_r;
   assign chanOut = chan_r;
   a_pulse_min_len: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && !busy_r) |=> busy_r [*5])
      else $error("pulse shorter than minimum width");
endmodule : pco_pulse_gen

/* File: hdl/pco_compare_top.sv */
// Purpose: position compare output with a 40-entry target table
// Assumes: feedback sample valid strobe synchronous to clk_sys
// Notes: registers reached over AXI4-Lite
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pco_cfg.svh"
module pco_compare_top
   import pco_pkg::*;
#(
   parameter int NPTS = 40,
   parameter int ENC_BITS = 23,
   parameter int TICK_CYC = `PCO_TICK_CYC
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fbValid,
   input wire logic signed [31:0] fbPos,
   output logic [3:0] chanOut
);
   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      for (int b = 0; b < 4; b++)
         if (strb[b])
            old[b*8 +: 8] = nw[b*8 +: 8];
      return old;
   endfunction : mergeStrb
   function automatic logic [5:0] tblIdx(input logic [11:0] addr);
      logic [11:0] off;
      off = addr - `PCO_OFS_TABLE;
      return off[8:3];
   endfunction : tblIdx
   function automatic logic tblHit(input logic [11:0] addr);
      return (addr >= `PCO_OFS_TABLE) && (addr <= `PCO_OFS_TABLE_END);
   endfunction : tblHit
   // -------------------------------------------------------------------
   // registers and table
   // -------------------------------------------------------------------
   logic en_r, enPrev_r;
   pco_mode_t mode_r;
   logic [3:0] open_r;
   logic [4:0] res_r;
   logic [10:0] width_r;
   logic [5:0] startIdx_r, endIdx_r, casStart_r, status_r, curIdx_r, upIdx_r;
   logic signed [31:0] live_r, zero_r, scaledPrev_r;
   logic [15:0] cycles_r, cycDone_r;
   logic signed [31:0] tgtMem [NPTS];
   logic [11:0] attrMem [NPTS];
   pco_state_t state_r;
   logic [11:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic awHeld_r, wHeld_r;
   // -------------------------------------------------------------------
   // AXI4-Lite write and read decode
   // -------------------------------------------------------------------
   wire wrCommit = awHeld_r && wHeld_r && !s_axi_bvalid;
   wire awHeld_nxt = (awHeld_r && !wrCommit) || (s_axi_awvalid && s_axi_awready);
   wire wHeld_nxt = (wHeld_r && !wrCommit) || (s_axi_wvalid && s_axi_wready);
   wire [11:0] wA = {awAddr_r[11:2], 2'b00};
   wire [5:0] wIdx = tblIdx(wA);
   wire wTbl = tblHit(wA) && (wIdx < 6'(NPTS));
   wire wReg = (wA <= `PCO_OFS_CASTART) && (wA != `PCO_OFS_STATUS) && (wA != `PCO_OFS_LIVE);
   wire wOk = wTbl || wReg || (wA == `PCO_OFS_STATUS) || (wA == `PCO_OFS_LIVE);
   wire tblWe = wrCommit && wTbl && !en_r;
   wire ctrlWe = wrCommit && (wA == `PCO_OFS_CTRL);
   wire [31:0] ctrlNew = mergeStrb({20'h0, open_r, 2'h0, mode_r, 3'h0, en_r}, wData_r, wStrb_r);
   wire [31:0] wMerged = mergeStrb(32'h0, wData_r, wStrb_r);
   // decoded at the take edge, so the answer belongs to this request, not the last one
   wire [11:0] rA = {s_axi_araddr[11:2], 2'b00};
   wire [5:0] rIdx = tblIdx(rA);
   wire rTbl = tblHit(rA) && (rIdx < 6'(NPTS));
   wire rOk = rTbl || (rA <= `PCO_OFS_CASTART);
   wire [31:0] rTblData = rA[2] ? {20'h0, attrMem[rIdx]} : tgtMem[rIdx];
   wire [31:0] rRegData =
      (rA == `PCO_OFS_CTRL) ? {20'h0, open_r, 2'h0, mode_r, 3'h0, en_r} :
      (rA == `PCO_OFS_RESOL) ? {27'h0, res_r} :
      (rA == `PCO_OFS_WIDTH) ? {21'h0, width_r} :
      (rA == `PCO_OFS_START) ? {26'h0, startIdx_r} :
      (rA == `PCO_OFS_END) ? {26'h0, endIdx_r} :
      (rA == `PCO_OFS_STATUS) ? {26'h0, status_r} :
      (rA == `PCO_OFS_LIVE) ? live_r :
      (rA == `PCO_OFS_ZERO) ? zero_r :
      (rA == `PCO_OFS_CYCLES) ? {16'h0, cycles_r} :
      (rA == `PCO_OFS_CASTART) ? {26'h0, casStart_r} : 32'h0;
   wire [31:0] rData = rTbl ? rTblData : rRegData;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 12'h0;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            awAddr_r <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         // ready kept as its own flop so the port leaves a register
         s_axi_awready <= !awHeld_nxt;
         s_axi_wready <= !wHeld_nxt;
         s_axi_bvalid <= wrCommit || (s_axi_bvalid && !s_axi_bready);
         if (wrCommit)
            s_axi_bresp <= wOk ? 2'h0 : 2'h2;
         // one cycle to raise arready, one to answer
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (s_axi_arvalid && s_axi_arready)
            s_axi_rvalid <= 1'b1;
         s_axi_rdata <= (s_axi_arvalid && s_axi_arready) ? rData : s_axi_rdata;
         s_axi_rresp <= (s_axi_arvalid && s_axi_arready) ? (rOk ? 2'h0 : 2'h2) : s_axi_rresp;
      end
   end
   // -------------------------------------------------------------------
   // feedback scaling and crossing candidates
   // -------------------------------------------------------------------
   wire [5:0] resBits = 6'(res_r) + 6'(`PCO_RES_BASE);
   wire [5:0] shiftAmt = (resBits >= 6'(ENC_BITS)) ? 6'h0 : 6'(ENC_BITS) - resBits;
   wire signed [31:0] scaledNow = fbPos >>> shiftAmt;
   wire signed [31:0] liveNxt = live_r + (scaledNow - scaledPrev_r);
   wire isCas = (mode_r == PCO_CYC_ABS);
   wire casRun = isCas && (state_r == PCO_ST_RUN);
   wire [5:0] idxA = (state_r == PCO_ST_SEEK) ? casStart_r : (isCas ? upIdx_r : curIdx_r);
   wire [5:0] idxB = upIdx_r - 6'h1;
   wire validA = (idxA < 6'(NPTS)) && (!casRun || (upIdx_r <= endIdx_r));
   wire validB = casRun && (upIdx_r > startIdx_r);
   logic upA, fireA, dnB, fireB, busy;
   pco_cross_det u_crossA (
      .prevPos(live_r),
      .curPos(liveNxt),
      .target(tgtMem[idxA]),
      .attrDir(attrMem[idxA][1:0]),
      .dirMask(casRun ? 2'b01 : 2'b11),
      .crossUp(upA),
      .crossDn(),
      .fire(fireA)
   );
   pco_cross_det u_crossB (
      .prevPos(live_r),
      .curPos(liveNxt),
      .target(tgtMem[idxB]),
      .attrDir(attrMem[idxB][1:0]),
      .dirMask(2'b10),
      .crossUp(),
      .crossDn(dnB),
      .fire(fireB)
   );
   // -------------------------------------------------------------------
   // compare sequencing
   // -------------------------------------------------------------------
   wire enRise = en_r && !enPrev_r;
   wire step = fbValid && (state_r != PCO_ST_IDLE) && en_r && !busy;
   wire seqRun = step && !isCas;
   wire skipA = (attrMem[idxA][1:0] == 2'b00);
   wire hitA = step && validA && fireA;
   wire hitB = step && validB && fireB;
   wire seqAdv = seqRun && validA && (skipA || fireA);
   wire atEnd = (curIdx_r == endIdx_r);
   wire fixDone = (cycDone_r + 16'h1 >= cycles_r);
   wire autoOff = seqAdv && atEnd &&
                  ((mode_r == PCO_SINGLE_ABS) || ((mode_r == PCO_FIX_INC) && fixDone));
   wire incMode = (mode_r == PCO_CYC_INC) || (mode_r == PCO_FIX_INC);
   wire startPulse = hitA || hitB;
   wire [11:0] hitAttr = hitA ? attrMem[idxA] : attrMem[idxB];
   wire [3:0] chanSel = hitAttr[`PCO_ATTR_CH_LSB +: 4] & open_r;
   wire [10:0] widthEff = (width_r < `PCO_WIDTH_MIN) ? `PCO_WIDTH_MIN : width_r;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         en_r <= 1'b0;
         enPrev_r <= 1'b0;
         mode_r <= PCO_SINGLE_ABS;
         open_r <= 4'h0;
         res_r <= `PCO_RES_RST;
         width_r <= `PCO_WIDTH_RST;
         startIdx_r <= 6'h0;
         endIdx_r <= 6'h0;
         casStart_r <= 6'h0;
         zero_r <= 32'h0;
         cycles_r <= 16'h0;
      end
      else
      begin
         enPrev_r <= en_r;
         // a software write to the control word wins over the automatic stop
         if (ctrlWe)
         begin
            en_r <= ctrlNew[`PCO_CTRL_EN_BIT];
            mode_r <= pco_mode_t'(ctrlNew[`PCO_CTRL_MODE_LSB +: 2]);
            open_r <= ctrlNew[`PCO_CTRL_OPEN_LSB +: 4];
         end
         else if (autoOff)
            en_r <= 1'b0;
         if (wrCommit && (wA == `PCO_OFS_RESOL))
            res_r <= wMerged[4:0];
         if (wrCommit && (wA == `PCO_OFS_WIDTH))
            width_r <= wMerged[10:0];
         if (wrCommit && (wA == `PCO_OFS_START))
            startIdx_r <= wMerged[5:0];
         if (wrCommit && (wA == `PCO_OFS_END))
            endIdx_r <= wMerged[5:0];
         if (wrCommit && (wA == `PCO_OFS_CASTART))
            casStart_r <= wMerged[5:0];
         if (wrCommit && (wA == `PCO_OFS_ZERO))
            zero_r <= wMerged;
         if (wrCommit && (wA == `PCO_OFS_CYCLES))
            cycles_r <= wMerged[15:0];
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (tblWe && !wA[2])
         tgtMem[wIdx] <= mergeStrb(tgtMem[wIdx], wData_r, wStrb_r);
      if (tblWe && wA[2])
         attrMem[wIdx] <= 12'(mergeStrb({20'h0, attrMem[wIdx]}, wData_r, wStrb_r));
   end
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= PCO_ST_IDLE;
         live_r <= 32'h0;
         scaledPrev_r <= 32'h0;
         status_r <= 6'h0;
         curIdx_r <= 6'h0;
         upIdx_r <= 6'h0;
         cycDone_r <= 16'h0;
      end
      else
      begin
         if (fbValid)
            scaledPrev_r <= scaledNow;
         if (!en_r)
         begin
            state_r <= PCO_ST_IDLE;
            status_r <= 6'h0;
            cycDone_r <= 16'h0;
         end
         else if (enRise)
         begin
            state_r <= isCas ? PCO_ST_SEEK : PCO_ST_RUN;
            live_r <= zero_r;
            curIdx_r <= startIdx_r;
            status_r <= isCas ? casStart_r : startIdx_r;
         end
         else
         begin
            if (fbValid)
               live_r <= (hitA && incMode) ? 32'h0 : liveNxt;
            unique case (state_r)
               PCO_ST_SEEK:
                  if (hitA)
                  begin
                     state_r <= PCO_ST_RUN;
                     status_r <= casStart_r;
                     upIdx_r <= upA ? casStart_r + 6'h1 : casStart_r;
                  end
               PCO_ST_RUN:
                  if (casRun && step && validA && upA)
                  begin
                     upIdx_r <= upIdx_r + 6'h1;
                     status_r <= upIdx_r;
                  end
                  else if (casRun && step && validB && dnB)
                  begin
                     upIdx_r <= idxB;
                     status_r <= idxB;
                  end
                  else if (seqAdv && atEnd && !autoOff)
                  begin
                     curIdx_r <= startIdx_r;
                     status_r <= startIdx_r;
                     cycDone_r <= cycDone_r + 16'h1;
                  end
                  else if (seqAdv && !atEnd)
                  begin
                     curIdx_r <= curIdx_r + 6'h1;
                     status_r <= curIdx_r + 6'h1;
                  end
               default:
                  state_r <= PCO_ST_IDLE;
            endcase
         end
      end
   end
   pco_pulse_gen #(
      .TICK_CYC(TICK_CYC)
   ) u_pulse (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(startPulse),
      .widthTicks(widthEff),
      .chanSel(chanSel),
      .busy(busy),
      .chanOut(chanOut)
   );
   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_enable_load_offset: assert property (enRise && !ctrlWe |=> live_r == $past(zero_r))
      else $error("live position not loaded with offset");
   a_disable_clears_status: assert property (!en_r |=> status_r == 6'h0)
      else $error("status not cleared when disabled");
   a_pulse_suspends: assert property (busy |-> !startPulse)
      else $error("compare fired during pulse");
   a_single_end_off: assert property (autoOff && !ctrlWe |=> !en_r ##1 status_r == 6'h0)
      else $error("end point did not disable compare");
   a_cyclic_restart: assert property (seqAdv && atEnd && !autoOff && en_r && !ctrlWe
      |=> curIdx_r == $past(startIdx_r))
      else $error("cyclic mode did not restart");
   a_inc_clear_live: assert property (hitA && incMode && en_r && !enRise |=> live_r == 32'h0)
      else $error("incremental hit did not clear position");
   a_channel_open: assert property (startPulse |=> (chanOut & ~$past(open_r)) == 4'h0)
      else $error("pulse on a channel not opened");
   a_seek_start_only: assert property (state_r == PCO_ST_SEEK && startPulse
      |-> idxA == casStart_r)
      else $error("output before cyclic start point");
   c_single_run: cover property (autoOff);
   c_cyc_wrap: cover property (seqAdv && atEnd && mode_r == PCO_CYC_INC);
   c_cas_down: cover property (hitB);
   c_pulse_out: cover property (startPulse ##1 chanOut != 4'h0);
endmodule : pco_compare_top

/* File: dv/pco_enc_model.sv */
// Purpose: encoder feedback source and watcher of the compare output port
// Assumes: one sample every PERIOD cycles, one position unit per sample
// Notes: goals stay small, so the position never wraps
`timescale 1ns/1ps
module pco_enc_model
#(
   parameter int PERIOD = 4
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic signed [31:0] goal,
   input wire logic [3:0] chanOut,
   input wire logic clrMon,
   output logic fbValid,
   output logic signed [31:0] fbPos,
   output logic [7:0] pulseCnt,
   output logic [7:0] hiLen,
   output logic [3:0] chSeen
);
   // ----------------------------------------
   // feedback and port watch
   // ----------------------------------------
   logic signed [31:0] pos_r;
   logic [7:0] div_r;
   logic [7:0] run_r;
   // 64 raw counts a unit: a 23-bit encoder seen at 17-bit resolution
   assign fbPos = pos_r <<< 6;
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         pos_r <= '0;
         div_r <= 8'h00;
         fbValid <= 1'b0;
      end
      else
      begin
         div_r <= (div_r == 8'(PERIOD - 1)) ? 8'h00 : div_r + 8'h01;
         // samples keep coming while standing still, so a stop on a target is seen
         fbValid <= (div_r == 8'h00);
         if (div_r == 8'h00 && pos_r != goal)
            pos_r <= (pos_r < goal) ? pos_r + 1 : pos_r - 1;
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (clrMon)
      begin
         pulseCnt <= 8'h00;
         chSeen <= 4'h0;
         run_r <= 8'h00;
         hiLen <= 8'h00;
      end
      else if (chanOut != 4'h0)
      begin
         run_r <= run_r + 8'h01;
         chSeen <= chSeen | chanOut;
         if (run_r == 8'h00)
            pulseCnt <= pulseCnt + 8'h01;
      end
      else
      begin
         if (run_r != 8'h00)
            hiLen <= run_r;
         run_r <= 8'h00;
      end
   end
endmodule : pco_enc_model

/* File: dv/position_compare_output_tb_top.sv */
// Purpose: register-driven bench for the position compare block
// Assumes: TICK_CYC of 2, so a width setting n gives 2n cycles
// Notes: expectations follow from the settings written
`timescale 1ns/1ps
`include "pco_cfg.svh"
module position_compare_output_tb_top;
   // ----------------------------------------
   // bench
   // ----------------------------------------
   logic clk_sys = 1'b0, rstn = 1'b0, clrMon = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, chanOut, chSeen;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fbValid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic signed [31:0] fbPos, goal = '0;
   logic [7:0] pulseCnt, hiLen;
   int badCount = 0, numChecks = 0, cyc = 0;
   always #10 clk_sys = ~clk_sys;
   pco_compare_top #(.TICK_CYC(2)) dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fbValid, .fbPos, .chanOut);
   pco_enc_model model (.clk_sys, .rstn, .goal, .chanOut, .clrMon, .fbValid, .fbPos,
      .pulseCnt, .hiLen, .chSeen);
   task giveVerdict;
      if (badCount == 0 && numChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : giveVerdict
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      numChecks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         badCount++;
      end
   endtask : chk
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
      end
      while ((s_axi_awvalid & ~s_axi_awready) | (s_axi_wvalid & ~s_axi_wready));
      do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : wr
   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp,
      input logic [1:0] er = 2'h0);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(nm, exp, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : rd
   task setPt(input int i, input logic [31:0] t, input logic [31:0] at);
      wr(`PCO_OFS_TABLE + 12'(8 * i), t);
      wr(`PCO_OFS_TABLE + 12'(8 * i + 4), at);
   endtask : setPt
   // settle time covers the longest pulse, so counts are final when read
   task moveBy(input int d);
      goal <= goal + d;
      @(posedge clk_sys);
      while (fbPos !== (goal <<< 6)) @(posedge clk_sys);
      repeat (30) @(posedge clk_sys);
   endtask : moveBy
   task mon(input logic [7:0] n, input logic [7:0] w, input logic [3:0] ch);
      chk("pulse count", {24'h0, n}, {24'h0, pulseCnt});
      chk("pulse width", {24'h0, w}, {24'h0, hiLen});
      chk("channels", {28'h0, ch}, {28'h0, chSeen});
      clrMon <= 1'b1;
      @(posedge clk_sys);
      clrMon <= 1'b0;
   endtask : mon
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         badCount++;
         giveVerdict;
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      clrMon <= 1'b0;
      rd("resolution", `PCO_OFS_RESOL, 32'h7);
      rd("width", `PCO_OFS_WIDTH, 32'h5);
      rd("unmapped", 12'h800, 32'h0, 2'h2);
      wr(12'h800, 32'h1, 2'h2);
      wr(`PCO_OFS_TABLE + 12'h138, 32'hFFFFFF00);
      rd("entry 39", `PCO_OFS_TABLE + 12'h138, 32'hFFFFFF00);
      wr(`PCO_OFS_ZERO, 32'h3);
      setPt(0, 32'h0A, 32'h301);
      setPt(1, 32'h28, 32'h401);
      wr(`PCO_OFS_END, 32'h1);
      wr(`PCO_OFS_CTRL, 32'h501);
      rd("live start", `PCO_OFS_LIVE, 32'h3);
      wr(`PCO_OFS_TABLE, 32'h7F);
      moveBy(37);
      mon(8'h2, 8'h0A, 4'h5);
      rd("ctrl", `PCO_OFS_CTRL, 32'h500);
      rd("status", `PCO_OFS_STATUS, 32'h0);
      rd("live", `PCO_OFS_LIVE, 32'h28);
      rd("entry 0", `PCO_OFS_TABLE, 32'h0A);
      wr(`PCO_OFS_ZERO, 32'h0);
      setPt(0, 32'h32, 32'h102);
      setPt(1, 32'h2D, 32'h0);
      setPt(2, 32'h14, 32'h203);
      wr(`PCO_OFS_END, 32'h2);
      wr(`PCO_OFS_CTRL, 32'hF01);
      moveBy(60);
      moveBy(-50);
      mon(8'h2, 8'h0A, 4'h3);
      setPt(0, 32'h5, 32'h401);
      wr(`PCO_OFS_END, 32'h0);
      wr(`PCO_OFS_CYCLES, 32'h2);
      wr(`PCO_OFS_WIDTH, 32'h6);
      for (int m = 1; m < 3; m++)
      begin
         wr(`PCO_OFS_CTRL, 32'h401 | 32'(m << 4));
         moveBy(17);
         mon(8'(4 - m), 8'h0C, 4'h4);
         rd("ctrl", `PCO_OFS_CTRL, 32'h400 | 32'(m << 4) | 32'(m == 1));
         wr(`PCO_OFS_CTRL, 32'h0);
      end
      // below the minimum the width setting acts as 5
      wr(`PCO_OFS_WIDTH, 32'h3);
      for (int i = 0; i < 3; i++) setPt(i, 32'(10 * (i + 1)), 32'h803);
      wr(`PCO_OFS_END, 32'h2);
      wr(`PCO_OFS_CASTART, 32'h1);
      wr(`PCO_OFS_CTRL, 32'h831);
      moveBy(35);
      mon(8'h2, 8'h0A, 4'h8);
      rd("status", `PCO_OFS_STATUS, 32'h2);
      wr(`PCO_OFS_CTRL, 32'h0);
      rd("status off", `PCO_OFS_STATUS, 32'h0);
      giveVerdict;
   end
endmodule : position_compare_output_tb_top
